// *** pkg/rxm_pkg.sv ***
// constants and carrier types shared by the receive mac datapath
package rxm_pkg;
   localparam int LANES = 8;
   localparam logic [3:0] LANE_N = 4'h8;
   localparam logic [3:0] FCS_N = 4'h4;
   // control characters and preamble bytes
   localparam logic [7:0] CH_START = 8'hfb;
   localparam logic [7:0] CH_TERM = 8'hfd;
   localparam logic [7:0] PRE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hd5;
   localparam logic [7:0] START_CTL = 8'h80;
   // reflected crc-32
   localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
   localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;
   // control frame decode and one-hot status
   localparam logic [15:0] ETYPE_CTRL = 16'h8808;
   localparam logic [15:0] OP_STD = 16'h0001;
   localparam logic [15:0] OP_PFC = 16'h0101;
   localparam logic [2:0] CLS_NONE = 3'h0;
   localparam logic [2:0] CLS_STD = 3'h1;
   localparam logic [2:0] CLS_PFC = 3'h2;
   localparam logic [2:0] CLS_OTHER = 3'h4;
   // flow control build modes
   localparam int FLOW_NONE = 0;
   localparam int FLOW_STD = 1;
   localparam int FLOW_PFC = 2;
   // register map, byte addresses
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_CRC = 12'h004;
   localparam logic [11:0] A_STAT = 12'h008;
   localparam int FWD_BIT = 0;
   localparam int STD_EN_BIT = 1;
   localparam int PFC_LSB = 8;
   localparam int PFC_MSB = 15;
   localparam int STRIP_BIT = 0;
   localparam logic [31:0] CTRL_MASK = 32'h0000_ff03;
   localparam logic [31:0] CTRL_RST = 32'h0000_ff02;
   localparam logic [31:0] CRC_MASK = 32'h0000_0001;
   localparam logic [31:0] CRC_RST = 32'h0000_0001;
   // one buffered word of a frame
   typedef struct packed {
      logic [63:0] data;
      logic [3:0] cnt;
      logic sop;
      logic eop;
      logic ferr;
      logic merr;
   } beat_t;
endpackage

// *** core/eth_rx_mac_datapath.sv ***
// receive mac datapath: preamble check, crc check, strip, frame filter
`timescale 1ns/100ps
`default_nettype none
module eth_rx_mac_datapath #(
   parameter int PRE_PASS = 0,
   parameter int CUSTOM_IF = 0,
   parameter int FCS_ALIGN = 1,
   parameter int FLOW_MODE = 1,
   parameter int DEPTH = 4
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // phy words, lane 0 in the top byte
   input wire logic [63:0] phy_data,
   input wire logic [7:0] phy_ctl,
   input wire logic phy_valid,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // client stream
   output logic [63:0] rx_data,
   output logic rx_valid,
   output logic rx_sop,
   output logic rx_eop,
   output logic [2:0] rx_empty,
   output logic [1:0] rx_error,
   output logic rx_fcs_error,
   output logic rx_fcs_valid,
   output logic [2:0] rx_ctrl_status,
   // gap octets, custom interface only
   output logic [63:0] gap_data,
   output logic gap_valid,
   // pause indications toward transmit
   output logic pause_std,
   output logic pause_pfc
);
   localparam int PW = $clog2(DEPTH);
   localparam int IDX = 1 + PRE_PASS;
   localparam int FDLY = (FCS_ALIGN != 0) ? 0 : 1;
   typedef enum logic {ST_IDLE, ST_FRAME} st_t;

   st_t st_r;
   rxm_pkg::beat_t mem [DEPTH];
   rxm_pkg::beat_t pb, hd, pk;
   logic [PW-1:0] wp_r, rp_r;
   logic [PW:0] cnt_r, eops_r;
   logic [31:0] crc_r, crc_nx, ctrl_r, strip_r;
   logic [15:0] ok_r, bad_r;
   logic [3:0] t;
   logic [2:0] cls, cls_now;
   logic first_r, drop_r, pend_v_r, pend_e_r;
   logic pre_ok, has_ctl, fin, merr, ferr, strip, short_end;
   logic retag, push, emit, drop_c, drop_now, eop_now, acc;

   function automatic logic [7:0] lane(input logic [63:0] d,
                                       input int i);
      return d[63-8*i -: 8];
   endfunction

   // byte-wise reflected crc: first bit into the divider is each
   // byte's lsb, so fcs x31 lands in bit 0 of its first byte
   function automatic logic [31:0] crc_word(input logic [31:0] c,
                                            input logic [63:0] d,
                                            input logic [3:0] n);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < rxm_pkg::LANES; i++) begin
         if (4'(i) < n) begin
            r = r ^ {24'h00_0000, lane(d, i)};
            for (int j = 0; j < 8; j++) begin
               r = r[0] ? ((r >> 1) ^ rxm_pkg::CRC_POLY) : (r >> 1);
            end
         end
      end
      return r;
   endfunction

   // lowest lane holding a control character, 8 when none
   always_comb begin
      t = rxm_pkg::LANE_N;
      for (int i = rxm_pkg::LANES - 1; i >= 0; i--) begin
         if (phy_ctl[rxm_pkg::LANES-1-i]) begin
            t = 4'(i);
         end
      end
   end

   // start must sit in lane 0; a start elsewhere never matches
   always_comb begin
      pre_ok = phy_ctl == rxm_pkg::START_CTL &&
               lane(phy_data, 0) == rxm_pkg::CH_START &&
               lane(phy_data, 7) == rxm_pkg::SFD_BYTE;
      for (int i = 1; i < 7; i++) begin
         if (lane(phy_data, i) != rxm_pkg::PRE_BYTE) begin
            pre_ok = 1'b0;
         end
      end
   end

   // end of frame: terminate is normal, any other control is malformed
   assign strip = strip_r[rxm_pkg::STRIP_BIT];
   assign has_ctl = t != rxm_pkg::LANE_N;
   assign fin = phy_valid && st_r == ST_FRAME && has_ctl;
   assign merr = lane(phy_data, int'(t[2:0])) != rxm_pkg::CH_TERM;
   assign crc_nx = crc_word(crc_r, phy_data, t);
   assign ferr = merr || crc_nx != rxm_pkg::CRC_RESIDUE;
   assign short_end = strip ? (t <= rxm_pkg::FCS_N) : (t == 4'h0);
   assign retag = fin && !first_r && short_end;
   assign push = phy_valid && !retag &&
                 ((st_r == ST_IDLE && pre_ok && PRE_PASS != 0) ||
                  st_r == ST_FRAME);

   // word to buffer; the fcs tail is cut from the last beat
   always_comb begin
      pb = '0;
      pb.data = phy_data;
      pb.cnt = rxm_pkg::LANE_N;
      pb.sop = (st_r == ST_IDLE) || first_r;
      if (fin) begin
         pb.eop = 1'b1;
         pb.merr = merr;
         pb.ferr = ferr;
         pb.cnt = strip ? t - rxm_pkg::FCS_N : t;
         if (first_r && short_end) begin
            pb.cnt = 4'h1;
            pb.merr = 1'b1;
            pb.ferr = 1'b1;
         end
      end
   end

   // frame state; after an end we wait for a fresh start, so a late
   // terminate never makes a second eop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
         crc_r <= rxm_pkg::CRC_INIT;
         first_r <= 1'b1;
      end else if (ce && phy_valid) begin
         case (st_r)
            ST_IDLE: begin
               if (pre_ok) begin
                  st_r <= ST_FRAME;
                  crc_r <= rxm_pkg::CRC_INIT;
                  first_r <= PRE_PASS == 0;
               end
            end
            ST_FRAME: begin
               crc_r <= crc_nx;
               first_r <= 1'b0;
               if (has_ctl) begin
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // frame buffer storage; a short tail retags the newest beat as
   // the last one instead of pushing a beat that holds only fcs
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wp_r] <= pb;
      end
      if (ce && retag) begin
         mem[wp_r - 1'b1].eop <= 1'b1;
         mem[wp_r - 1'b1].cnt <= strip ? t + rxm_pkg::FCS_N
                                      : rxm_pkg::LANE_N;
         mem[wp_r - 1'b1].ferr <= ferr;
         mem[wp_r - 1'b1].merr <= merr;
      end
   end

   // hold back until the ethertype word is in, or drain on an end
   assign hd = mem[rp_r];
   assign pk = mem[rp_r + PW'(IDX)];
   assign emit = cnt_r != '0 && (cnt_r > (PW+1)'(IDX) || eops_r != '0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         eops_r <= '0;
      end else if (ce) begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (emit) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(emit);
         eops_r <= eops_r + (PW+1)'((push && pb.eop) || retag)
                          - (PW+1)'(emit && hd.eop);
      end
   end

   // classify at sop from the buffered type and opcode word
   always_comb begin
      cls = rxm_pkg::CLS_NONE;
      if (cnt_r > (PW+1)'(IDX) && pk.data[31:16] == rxm_pkg::ETYPE_CTRL) begin
         if (pk.data[15:0] == rxm_pkg::OP_STD) begin
            cls = rxm_pkg::CLS_STD;
         end else if (pk.data[15:0] == rxm_pkg::OP_PFC) begin
            cls = rxm_pkg::CLS_PFC;
         end else begin
            cls = rxm_pkg::CLS_OTHER;
         end
      end
      for (int k = 0; k < IDX; k++) begin
         if (mem[rp_r + PW'(k)].eop) begin
            cls = rxm_pkg::CLS_NONE;
         end
      end
   end

   // only the pause kind of the built mode is withheld
   assign drop_c = !ctrl_r[rxm_pkg::FWD_BIT] &&
      ((FLOW_MODE == rxm_pkg::FLOW_STD && cls == rxm_pkg::CLS_STD) ||
       (FLOW_MODE == rxm_pkg::FLOW_PFC && cls == rxm_pkg::CLS_PFC));
   assign drop_now = hd.sop ? drop_c : drop_r;
   assign cls_now = hd.sop ? cls : rx_ctrl_status;
   assign eop_now = emit && hd.eop && !drop_now;

   // client outputs, all registered on clk
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data <= '0;
         rx_valid <= 1'b0;
         rx_sop <= 1'b0;
         rx_eop <= 1'b0;
         rx_empty <= 3'h0;
         rx_error <= 2'h0;
         rx_ctrl_status <= rxm_pkg::CLS_NONE;
         drop_r <= 1'b0;
      end else if (ce) begin
         rx_data <= hd.data;
         rx_valid <= emit && !drop_now;
         rx_sop <= emit && hd.sop && !drop_now;
         rx_eop <= eop_now;
         rx_empty <= eop_now ? 3'(rxm_pkg::LANE_N - hd.cnt) : 3'h0;
         rx_error <= eop_now ? {hd.ferr, hd.merr} : 2'h0;
         if (emit && hd.sop) begin
            rx_ctrl_status <= cls;
            drop_r <= drop_c;
         end
      end
   end

   // fcs report: on the eop beat, or one cycle later when unaligned
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_fcs_valid <= 1'b0;
         rx_fcs_error <= 1'b0;
         pend_v_r <= 1'b0;
         pend_e_r <= 1'b0;
      end else if (ce) begin
         pend_v_r <= eop_now;
         pend_e_r <= eop_now && hd.ferr;
         if (FCS_ALIGN != 0) begin
            rx_fcs_valid <= eop_now;
            rx_fcs_error <= eop_now && hd.ferr;
         end else begin
            rx_fcs_valid <= pend_v_r;
            rx_fcs_error <= pend_e_r;
         end
      end
   end

   // pause action and frame counters; acts even on withheld frames
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pause_std <= 1'b0;
         pause_pfc <= 1'b0;
         ok_r <= 16'h0000;
         bad_r <= 16'h0000;
      end else if (ce) begin
         pause_std <= emit && hd.eop && !hd.ferr &&
            FLOW_MODE == rxm_pkg::FLOW_STD && cls_now == rxm_pkg::CLS_STD &&
            ctrl_r[rxm_pkg::STD_EN_BIT];
         pause_pfc <= emit && hd.eop && !hd.ferr &&
            FLOW_MODE == rxm_pkg::FLOW_PFC && cls_now == rxm_pkg::CLS_PFC &&
            ctrl_r[rxm_pkg::PFC_MSB:rxm_pkg::PFC_LSB] != 8'h00;
         if (emit && hd.eop && !hd.ferr) begin
            ok_r <= ok_r + 1'b1;
         end
         if (emit && hd.eop && hd.merr) begin
            bad_r <= bad_r + 1'b1;
         end
      end
   end

   // gap words pass out only on the custom interface
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_valid <= 1'b0;
         gap_data <= '0;
      end else if (ce) begin
         gap_valid <= CUSTOM_IF != 0 && phy_valid &&
                      st_r == ST_IDLE && !pre_ok;
         gap_data <= phy_data;
      end
   end

   // apb slave, one wait state so read data comes from a flop
   assign acc = psel && penable && pready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
         ctrl_r <= rxm_pkg::CTRL_RST;
         strip_r <= rxm_pkg::CRC_RST;
      end else if (ce) begin
         pready <= psel && penable && !pready;
         prdata <= '0;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            case (paddr)
               rxm_pkg::A_CTRL: prdata <= ctrl_r;
               rxm_pkg::A_CRC: prdata <= strip_r;
               rxm_pkg::A_STAT: prdata <= {bad_r, ok_r};
               default: pslverr <= 1'b1;
            endcase
         end
         if (acc && pwrite) begin
            case (paddr)
               rxm_pkg::A_CTRL: ctrl_r <= pwdata & rxm_pkg::CTRL_MASK;
               rxm_pkg::A_CRC: strip_r <= pwdata & rxm_pkg::CRC_MASK;
               default: ;
            endcase
         end
      end
   end

   // checks; helper tracks whether a delivered packet is open
   logic in_pkt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_pkt_r <= 1'b0;
      end else if (ce && rx_valid) begin
         in_pkt_r <= !rx_eop;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);

   sequence eop_beat;
      rx_valid && rx_eop;
   endsequence
   sequence fcs_rep;
      rx_fcs_valid;
   endsequence

   sop_first_a: assert property (rx_valid && !in_pkt_r |-> rx_sop)
      else $error("packet does not open with sop");
   stat_hold_a: assert property (rx_valid && !rx_sop |-> $stable(rx_ctrl_status))
      else $error("control status changed inside a packet");
   fcs_pair_a: assert property (rx_fcs_error |-> rx_fcs_valid)
      else $error("fcs error without fcs valid");
   fcs_time_a: assert property (eop_beat |-> ##FDLY fcs_rep)
      else $error("fcs report not at its slot after eop");
   mal_fcs_a: assert property (rx_error[0] |-> rx_error[1] && rx_eop)
      else $error("malformed end without fcs error");
   empty_mid_a: assert property (rx_valid && !rx_eop |-> rx_empty == 3'h0)
      else $error("empty nonzero before eop");
   pre_check_a: assert property (st_r == ST_IDLE && phy_valid && !pre_ok |=> st_r == ST_IDLE)
      else $error("frame opened without a valid preamble");
   // a fresh start may follow the end word at once, so the second
   // cycle accepts a frame that the word before it opened
   end_idle_a: assert property (fin |=> st_r == ST_IDLE ##1
      (st_r == ST_IDLE || $past(ce && phy_valid && pre_ok)))
      else $error("frame still open after its end");
   pause_gate_a: assert property (pause_std |-> FLOW_MODE == rxm_pkg::FLOW_STD && $past(ctrl_r[rxm_pkg::STD_EN_BIT]))
      else $error("pause acted on while disabled");
   fwd_gate_a: assert property (rx_sop && rx_valid && rx_ctrl_status == rxm_pkg::CLS_STD && FLOW_MODE == rxm_pkg::FLOW_STD |-> $past(ctrl_r[rxm_pkg::FWD_BIT]))
      else $error("pause frame forwarded while withheld");
endmodule
`default_nettype wire

// *** verif/rx_sink.sv ***
// client sink model: gathers delivered bytes and per-frame status
`timescale 1ns/100ps
`default_nettype none
module rx_sink (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // client stream from the mac
   input wire logic [63:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_sop,
   input wire logic rx_eop,
   input wire logic [2:0] rx_empty,
   input wire logic [1:0] rx_error,
   input wire logic rx_fcs_error,
   input wire logic rx_fcs_valid,
   input wire logic [2:0] rx_ctrl_status,
   // side indications
   input wire logic gap_valid,
   input wire logic pause_std
);
   logic [7:0] got[$];
   logic [1:0] err;
   logic fe;
   logic [2:0] cs;
   int nfr = 0;
   int pauses = 0;
   int gaps = 0;
   int mism = 0;
   // the sink never stalls: the stream offers no back-pressure
   always @(posedge clk) begin
      if (rst_n) begin
         if (rx_valid) begin
            if (rx_sop) begin
               got.delete();
               cs = rx_ctrl_status;
            end
            if (rx_ctrl_status !== cs) mism++;
            for (int i = 0; i < 8 - (rx_eop ? rx_empty : 0); i++)
               got.push_back(rx_data[63-8*i -: 8]);
            if (rx_eop) begin
               nfr++;
               err = rx_error;
               if (rx_fcs_valid !== 1'b1) mism++; // fcs slot lines up
            end
         end
         if (rx_fcs_valid) fe = rx_fcs_error;
         if (gap_valid) gaps++;
         if (pause_std) pauses++;
      end
   end
endmodule
`default_nettype wire

// *** verif/eth_rx_mac_datapath_test.sv ***
// self-checking bench for the receive mac datapath
`timescale 1ns/100ps
`default_nettype none
module eth_rx_mac_datapath_test;
   logic clk, rst_n, ce, phy_valid, psel, penable, pwrite;
   logic [63:0] phy_data, rx_data, gap_data;
   logic [7:0] phy_ctl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er, rx_valid, rx_sop, rx_eop;
   logic rx_fcs_error, rx_fcs_valid, gap_valid, pause_std, pause_pfc;
   logic [2:0] rx_empty, rx_ctrl_status;
   logic [1:0] rx_error;
   logic [31:0] seed = 32'h0000_002b;
   logic [7:0] fb[$];
   logic [7:0] ends[3] = '{8'hfe, 8'h07, 8'hfb};
   int errors = 0;
   int samples_checked = 0;
   int base, pb, good_n = 0, bad_n = 0;

   eth_rx_mac_datapath uut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .phy_data(phy_data), .phy_ctl(phy_ctl), .phy_valid(phy_valid),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_sop(rx_sop),
      .rx_eop(rx_eop), .rx_empty(rx_empty), .rx_error(rx_error),
      .rx_fcs_error(rx_fcs_error), .rx_fcs_valid(rx_fcs_valid),
      .rx_ctrl_status(rx_ctrl_status), .gap_data(gap_data),
      .gap_valid(gap_valid), .pause_std(pause_std), .pause_pfc(pause_pfc));
   rx_sink sink (.clk(clk), .rst_n(rst_n), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_eop(rx_eop),
      .rx_empty(rx_empty), .rx_error(rx_error),
      .rx_fcs_error(rx_fcs_error), .rx_fcs_valid(rx_fcs_valid),
      .rx_ctrl_status(rx_ctrl_status), .gap_valid(gap_valid),
      .pause_std(pause_std));

   // pfc indications must stay quiet in the standard flow build
   int pfc_n = 0;
   always @(posedge clk) begin
      if (pause_pfc === 1'b1) pfc_n++;
   end

   // 125 mhz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // a hang is cut short long after the tests should have ended
   initial begin
      #200000;
      errors++;
      end_sim();
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // apb master: holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic word(input logic [63:0] d, input logic [7:0] c);
      @(posedge clk);
      phy_data <= d;
      phy_ctl <= c;
      phy_valid <= 1'b1;
   endtask

   // frame bytes with a reflected crc appended, low fcs byte first
   task automatic build(input int len, input logic [15:0] op,
                        input logic ctl);
      logic [31:0] c;
      fb.delete();
      for (int i = 0; i < len; i++) fb.push_back(8'(rnd()));
      fb[12] = ctl ? rxm_pkg::ETYPE_CTRL[15:8] : 8'h00;
      fb[13] = rxm_pkg::ETYPE_CTRL[7:0];
      fb[14] = op[15:8];
      fb[15] = op[7:0];
      c = 32'hffff_ffff;
      foreach (fb[i]) begin
         c ^= {24'h00_0000, fb[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ rxm_pkg::CRC_POLY : c >> 1;
      end
      c = ~c;
      for (int i = 0; i < 4; i++) fb.push_back(c[8*i +: 8]);
   endtask

   // start word (pre 1: bad preamble, 2: start on lane 1), data, end
   task automatic send(input int pre, input logic [7:0] endc);
      int n, p;
      logic [63:0] d;
      logic [7:0] c;
      n = fb.size();
      base = sink.nfr;
      pb = sink.pauses;
      d = {rxm_pkg::CH_START, {6{rxm_pkg::PRE_BYTE}}, rxm_pkg::SFD_BYTE};
      c = rxm_pkg::START_CTL;
      if (pre == 1) d[23:16] = 8'h54;
      if (pre == 2) begin
         d = d >> 8;
         c = 8'h40;
      end
      word(d, c);
      for (int w = 0; w * 8 <= n; w++) begin
         for (int l = 0; l < 8; l++) begin
            p = w * 8 + l;
            d[63-8*l -: 8] = p < n ? fb[p] : (p == n ? endc : 8'h07);
            c[7-l] = p >= n;
         end
         word(d, c);
      end
      repeat (12) word({8{8'h07}}, 8'hff);
   endtask

   task automatic expect_frame(input logic strip, input logic [1:0] e,
                               input logic [2:0] cs);
      int m;
      m = strip ? fb.size() - 4 : fb.size();
      check(sink.nfr - base, 1);
      check(sink.err, e);
      check(sink.fe, e[1]);
      check(sink.cs, cs);
      if (e == 2'b00) begin
         check(sink.got.size(), m);
         for (int i = 0; i < m; i++) check(sink.got[i], fb[i]);
      end
   endtask

   initial begin
      ce = 1'b1;
      phy_valid = 1'b0;
      phy_data = 64'h0;
      phy_ctl = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // register reset values, a read-only and an unmapped place
      apb(1'b0, rxm_pkg::A_CTRL, 32'h0);
      check(rd, rxm_pkg::CTRL_RST);
      apb(1'b0, rxm_pkg::A_CRC, 32'h0);
      check(rd, 32'h0000_0001);
      apb(1'b0, 12'hff0, 32'h0);
      check(er, 1'b1);
      apb(1'b1, rxm_pkg::A_STAT, 32'hffff_ffff);
      check(er, 1'b0);
      $display("test registers done");
      // good frames of varied length, fcs stripped then kept
      for (int k = 0; k < 8; k++) begin
         if (k == 4) apb(1'b1, rxm_pkg::A_CRC, 32'h0000_0000);
         build(k % 4 == 0 ? 60 : 20 + rnd() % 60, 16'h0, 1'b0);
         send(0, rxm_pkg::CH_TERM);
         expect_frame(k < 4, 2'b00, 3'b000);
         good_n++;
      end
      apb(1'b1, rxm_pkg::A_CRC, 32'h0000_0001);
      $display("test good frames done");
      // corrupt fcs, then bad endings followed by a late terminate
      build(40, 16'h0, 1'b0);
      fb[42] ^= 8'h01;
      send(0, rxm_pkg::CH_TERM);
      expect_frame(1'b1, 2'b10, 3'b000);
      foreach (ends[i]) begin
         build(40, 16'h0, 1'b0);
         send(0, ends[i]);
         word({rxm_pkg::CH_TERM, {7{8'h07}}}, 8'hff);
         repeat (8) word({8{8'h07}}, 8'hff);
         expect_frame(1'b1, 2'b11, 3'b000);
         bad_n++;
      end
      // broken preamble and start away from lane 0 are ignored
      for (int p = 1; p < 3; p++) begin
         build(40, 16'h0, 1'b0);
         send(p, rxm_pkg::CH_TERM);
         check(sink.nfr - base, 0);
      end
      $display("test errored frames done");
      // pause withheld and acted on; other control frames pass
      build(60, rxm_pkg::OP_STD, 1'b1);
      send(0, rxm_pkg::CH_TERM);
      check(sink.nfr - base, 0);
      check(sink.pauses - pb, 1);
      build(60, rxm_pkg::OP_PFC, 1'b1);
      send(0, rxm_pkg::CH_TERM);
      expect_frame(1'b1, 2'b00, rxm_pkg::CLS_PFC);
      check(pfc_n, 0);
      build(60, 16'h0002, 1'b1);
      send(0, rxm_pkg::CH_TERM);
      expect_frame(1'b1, 2'b00, rxm_pkg::CLS_OTHER);
      apb(1'b1, rxm_pkg::A_CTRL, 32'h0000_ff01);
      build(60, rxm_pkg::OP_STD, 1'b1);
      send(0, rxm_pkg::CH_TERM);
      expect_frame(1'b1, 2'b00, rxm_pkg::CLS_STD);
      check(sink.pauses - pb, 0);
      good_n += 4;
      $display("test control frames done");
      // frame counters, gap port and per-beat status steadiness
      apb(1'b0, rxm_pkg::A_STAT, 32'h0);
      check(rd, {16'(bad_n), 16'(good_n)});
      check(sink.gaps, 0);
      check(sink.mism, 0);
      $display("test status done");
      end_sim();
   end
endmodule
`default_nettype wire
